// ### include/css_params.svh
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define CSS_CLK_MHZ           100

// ****************************************************************
// Start-up timing, figures in their own unit
// ****************************************************************
`define CSS_T_UV_DELAY_US     10
`define CSS_T_EN_START_US     250
`define CSS_T_TM_US           100
`define CSS_T_FLAG_MS         2
`define CSS_T_FAULT_RESP_US   10

// Start-up timing in clock cycles; least times, so round up
`define CSS_T_UV_DELAY_CYC    ((`CSS_T_UV_DELAY_US * `CSS_CLK_MHZ * 1000 + 999) / 1000)
`define CSS_T_EN_START_CYC    ((`CSS_T_EN_START_US * `CSS_CLK_MHZ * 1000 + 999) / 1000)
`define CSS_T_TM_CYC          ((`CSS_T_TM_US * `CSS_CLK_MHZ * 1000 + 999) / 1000)
`define CSS_T_FLAG_CYC        (`CSS_T_FLAG_MS * 1000 * `CSS_CLK_MHZ)
// Longest fault response; a bound, so round down
`define CSS_T_FAULT_RESP_CYC  ((`CSS_T_FAULT_RESP_US * `CSS_CLK_MHZ * 1000) / 1000)

// ****************************************************************
// Temperature PWM
// ****************************************************************
`define CSS_PWM_FREQ_KHZ      250
`define CSS_PWM_PERIOD_CYC    ((`CSS_CLK_MHZ * 1000) / `CSS_PWM_FREQ_KHZ)
`define CSS_PWM_LAST          9'h18F
`define CSS_TM_REF_MV         16'sh04F6
`define CSS_TM_REF_C          16'sh001B
`define CSS_TM_GAIN_MV        16'sh000A
`define CSS_TM_HIGH_MV        18'h00CE4
`define CSS_TEMP_MIN_C        (-16'sh0028)
`define CSS_TEMP_MAX_C        16'sh007D
`define CSS_DUTY_MIN          9'h049
`define CSS_DUTY_MAX          9'h110

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define CSS_CNT_W             18
`define CSS_SYNC_W            4
`define CSS_SYNC_RST          4'h0
`define CSS_TEMP_RST          8'sh1B

`endif

// ### include/css_pkg.sv
package css_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		CSS_OFF   = 3'h0,
		CSS_QUAL  = 3'h1,
		CSS_START = 3'h2,
		CSS_SOFT  = 3'h3,
		CSS_RUN   = 3'h4,
		CSS_LATCH = 3'h5
	} css_state_e;

	typedef logic [17:0]        css_count_t;
	typedef logic signed [7:0]  css_temp_t;
	typedef logic [8:0]         css_duty_t;

endpackage

// ### include/css_pwm_if.sv
`timescale 1ns/1ps

// Sequencer to temperature PWM generator
interface css_pwm_if;
	logic               run;
	css_pkg::css_temp_t temp_c;
	logic               level;
	logic               drive_n;

	modport ctrl (output run, output temp_c, input level, input drive_n);
	modport gen  (input run, input temp_c, output level, output drive_n);
endinterface

// ### core/css_sync.sv
`timescale 1ns/1ps
`include "css_params.svh"

module css_sync (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [`CSS_SYNC_W-1:0]  async_i,
	output logic      [`CSS_SYNC_W-1:0]  sync_o
);

	logic [`CSS_SYNC_W-1:0] meta_reg;
	logic [`CSS_SYNC_W-1:0] meta_next;
	logic [`CSS_SYNC_W-1:0] hold_reg;
	logic [`CSS_SYNC_W-1:0] hold_next;

	// First stage is read only by the second stage
	always_comb begin
		meta_next = async_i;
		hold_next = meta_reg;
	end

	// Two flops per line, cleared at reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_reg <= `CSS_SYNC_RST;
			hold_reg <= `CSS_SYNC_RST;
		end else begin
			meta_reg <= meta_next;
			hold_reg <= hold_next;
		end
	end

	assign sync_o = hold_reg;

endmodule

// ### core/css_temp_pwm.sv
`timescale 1ns/1ps
`include "css_params.svh"

module css_temp_pwm (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  rstn_i,
	// Sequencer side
	css_pwm_if.gen     pwm
);

	// ****************************************************************
	// Temperature to duty count
	// ****************************************************************

	// Averaged level is 1.27 V at 27 C plus 10 mV per degree of a 3.3 V swing
	function automatic css_pkg::css_duty_t css_duty(input css_pkg::css_temp_t t);
		logic signed [15:0] tc;
		logic signed [15:0] mv;
		logic        [19:0] num;
		logic        [19:0] q;
		tc = {{8{t[7]}}, t};
		if (tc < `CSS_TEMP_MIN_C)
			tc = `CSS_TEMP_MIN_C;
		if (tc > `CSS_TEMP_MAX_C)
			tc = `CSS_TEMP_MAX_C;
		mv  = `CSS_TM_REF_MV + `CSS_TM_GAIN_MV * (tc - `CSS_TM_REF_C);
		// Period is 400 cycles, so counts = mv * 400 / 3300, rounded; the product needs 20 bits
		num = 20'(mv) * 20'(`CSS_PWM_PERIOD_CYC) + 20'(`CSS_TM_HIGH_MV >> 1);
		q   = num / 20'(`CSS_TM_HIGH_MV);
		if (q < 20'(`CSS_DUTY_MIN))
			q = 20'(`CSS_DUTY_MIN);
		if (q > 20'(`CSS_DUTY_MAX))
			q = 20'(`CSS_DUTY_MAX);
		return q[8:0];
	endfunction

	logic [8:0]          cnt_reg;
	logic [8:0]          cnt_next;
	css_pkg::css_duty_t  duty_reg;
	css_pkg::css_duty_t  duty_next;
	logic                level_reg;
	logic                level_next;
	logic                drive_n_reg;
	logic                drive_n_next;

	// ****************************************************************
	// Period counter and comparator
	// ****************************************************************

	// Duty is taken only at period start so a pulse is never cut short;
	// idle parks the count on its last step so the first period is whole
	always_comb begin
		cnt_next     = `CSS_PWM_LAST;
		duty_next    = duty_reg;
		level_next   = 1'b0;
		drive_n_next = 1'b1;
		if (pwm.run) begin
			cnt_next     = (cnt_reg == `CSS_PWM_LAST) ? 9'h000 : cnt_reg + 9'h001; // see R1
			if (cnt_next == 9'h000)
				duty_next = css_duty(pwm.temp_c);                            // see R3
			level_next   = (cnt_next == 9'h000) ? 1'b1 : (cnt_next < duty_next); // see R2
			drive_n_next = 1'b0;
		end
	end

	// Registers; while idle the pin is released to its pull-up
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_reg     <= `CSS_PWM_LAST;
			duty_reg    <= `CSS_DUTY_MIN;
			level_reg   <= 1'b0;
			drive_n_reg <= 1'b1;
		end else begin
			cnt_reg     <= cnt_next;
			duty_reg    <= duty_next;
			level_reg   <= level_next;
			drive_n_reg <= drive_n_next;
		end
	end

	assign pwm.level   = level_reg;
	assign pwm.drive_n = drive_n_reg;

endmodule

// ### core/css_converter_status_sequencer.sv
// What this block does
// R1 - Temperature pin is a steady 250 kHz PWM
// R2 - PWM duty reports controller temperature
// R3 - Duty: 1.27 V at 27 C, 10 mV/C
// R4 - PWM valid 100 us after power stage on
// R5 - Enable low turns bias and power off
// R6 - Floating enable counts as asserted (pull-up)
// R7 - Power stage on 250 us after qualification
// R8 - Arrays tie enables together for common start
// R9 - Ready flag rises 2 ms after power on
// R10 - Any protection fault pulls flag low
// R11 - Flag falls within 10 us of fault
// R12 - Fault latches off until primary undervoltage
// R13 - Flag stays low while latched, soft start frees
`timescale 1ns/1ps
`include "css_params.svh"

module css_converter_status_sequencer #(
	parameter int unsigned T_UV_DELAY_CYC = `CSS_T_UV_DELAY_CYC,
	parameter int unsigned T_EN_START_CYC = `CSS_T_EN_START_CYC,
	parameter int unsigned T_TM_CYC       = `CSS_T_TM_CYC,
	parameter int unsigned T_FLAG_CYC     = `CSS_T_FLAG_CYC
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	// Host pin, resolved through its pull-up
	input  wire logic                enable_i,
	// Primary voltage comparators and protection summary
	input  wire logic                pri_above_recovery_i,
	input  wire logic                pri_below_lockout_i,
	input  wire logic                fault_i,
	// Temperature sensor, same clock domain
	input  wire css_pkg::css_temp_t  temp_c_i,
	input  wire logic                temp_valid_i,
	// Power train control
	output logic                     bias_en_o,
	output logic                     power_stage_o,
	// Status pins
	output logic                     temperature_pwm_out_o,
	output logic                     temperature_pwm_oe_n_o,
	output logic                     ready_fault_flag_o,
	output logic                     fault_latched_o
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************

	logic [`CSS_SYNC_W-1:0] pins_async;
	logic [`CSS_SYNC_W-1:0] pins_sync;

	// Synchronised copies, one per pin
	logic                   en_s;
	logic                   above_s;
	logic                   below_s;
	logic                   fault_s;

	// All four are asynchronous pins, so two flops each
	assign pins_async = {fault_i, pri_below_lockout_i, pri_above_recovery_i, enable_i};

	css_sync u_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.async_i (pins_async),
		.sync_o  (pins_sync)
	);

	// The pull-up makes an open enable read high; no special case here
	assign en_s    = pins_sync[0]; // see R6
	assign above_s = pins_sync[1];
	assign below_s = pins_sync[2];
	assign fault_s = pins_sync[3];

	// ****************************************************************
	// Temperature sample
	// ****************************************************************

	css_pkg::css_temp_t temp_reg;
	css_pkg::css_temp_t temp_next;

	// Sensor words come from this clock, so they skip the synchroniser
	// Hold the last good sensor reading between conversions
	always_comb begin
		temp_next = temp_reg;
		if (temp_valid_i)
			temp_next = temp_c_i;
	end

	// Room temperature until the first conversion lands
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			temp_reg <= `CSS_TEMP_RST;
		else
			temp_reg <= temp_next;
	end

	// ****************************************************************
	// Decoders
	// ****************************************************************

	// True on the last cycle of an n-cycle wait, so the move lands on cycle n
	function automatic logic css_at_count(input css_pkg::css_count_t c, input int unsigned n);
		return (c == `CSS_CNT_W'(n - 1));
	endfunction

	// States in which the power stage is switching
	function automatic logic css_powered(input css_pkg::css_state_e s);
		return (s == css_pkg::CSS_SOFT) || (s == css_pkg::CSS_RUN);
	endfunction

	// ****************************************************************
	// Start-up sequencer
	// ****************************************************************

	css_pkg::css_state_e state_reg;
	css_pkg::css_state_e state_next;
	css_pkg::css_count_t cnt_reg;
	css_pkg::css_count_t cnt_next;

	// Start condition and terminal-count strobes
	logic                qualified;
	logic                uv_done;
	logic                start_done;
	logic                tm_done;
	logic                flag_done;

	// Terminal counts; each wait lasts exactly its figure in cycles
	assign uv_done    = css_at_count(cnt_reg, T_UV_DELAY_CYC);
	assign start_done = css_at_count(cnt_reg, T_EN_START_CYC);
	assign tm_done    = css_at_count(cnt_reg, T_TM_CYC);
	assign flag_done  = css_at_count(cnt_reg, T_FLAG_CYC);

	// Both start conditions must hold together
	assign qualified  = en_s && above_s;

	// Next state; fault outranks enable, undervoltage outranks both except in the undervoltage delay
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// Idle; a fault here is ignored as nothing is powered
			css_pkg::CSS_OFF: begin
				if (qualified)
					state_next = css_pkg::CSS_QUAL;
			end
			// Undervoltage delay; both start conditions must stay true
			css_pkg::CSS_QUAL: begin
				if (fault_s)
					state_next = css_pkg::CSS_LATCH;
				else if (!qualified)
					state_next = css_pkg::CSS_OFF;                // see R5
				else if (uv_done)
					state_next = css_pkg::CSS_START;
			end
			// Start delay; power stage still off
			css_pkg::CSS_START: begin
				if (below_s)
					state_next = css_pkg::CSS_OFF;
				else if (fault_s)
					state_next = css_pkg::CSS_LATCH;              // see R10
				else if (!en_s)
					state_next = css_pkg::CSS_OFF;                // see R5
				else if (start_done)
					state_next = css_pkg::CSS_SOFT;               // see R7
			end
			// Soft start; power on, flag still low
			css_pkg::CSS_SOFT: begin
				if (below_s)
					state_next = css_pkg::CSS_OFF;
				else if (fault_s)
					state_next = css_pkg::CSS_LATCH;              // see R10
				else if (!en_s)
					state_next = css_pkg::CSS_OFF;                // see R5
				else if (flag_done)
					state_next = css_pkg::CSS_RUN;                // see R9
			end
			// Running; flag high until a shutdown
			css_pkg::CSS_RUN: begin
				if (below_s)
					state_next = css_pkg::CSS_OFF;
				else if (fault_s)
					state_next = css_pkg::CSS_LATCH;              // see R10
				else if (!en_s)
					state_next = css_pkg::CSS_OFF;                // see R5
			end
			css_pkg::CSS_LATCH: begin
				// Enable alone cannot clear a fault; only primary undervoltage
				if (below_s)
					state_next = css_pkg::CSS_OFF;                // see R12
			end
			default: begin
				state_next = css_pkg::CSS_OFF;
			end
		endcase
	end

	// Timer restarts on every state change and idles where nothing is timed
	always_comb begin
		cnt_next = '0;
		if (state_next == state_reg) begin
			case (state_reg)
				css_pkg::CSS_QUAL,
				css_pkg::CSS_START,
				css_pkg::CSS_SOFT: begin
					cnt_next = cnt_reg + `CSS_CNT_W'(1);
				end
				default: begin
					cnt_next = '0;
				end
			endcase
		end
	end

	// State and timer registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= css_pkg::CSS_OFF;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ****************************************************************
	// Control outputs
	// ****************************************************************

	logic bias_reg;
	logic bias_next;
	logic power_reg;
	logic power_next;
	logic flag_reg;
	logic flag_next;
	logic latch_reg;
	logic latch_next;

	// Run request to the temperature PWM generator
	logic pwm_run_reg;
	logic pwm_run_next;

	// Decoded from the next state, bias from the enable, so bias, power, flag and latch move on the same edge
	always_comb begin
		// Bias follows enable alone, latched or not
		bias_next    = en_s;                                             // see R5
		// The power stage switches through soft start and run
		power_next   = css_powered(state_next);                          // see R5
		// Only a finished soft start raises the flag again
		flag_next    = (state_next == css_pkg::CSS_RUN);                 // see R13
		// Mirrors the latched state for the host
		latch_next   = (state_next == css_pkg::CSS_LATCH);
		// PWM starts part way into soft start; the generator's flop adds a cycle
		pwm_run_next = css_powered(state_next) &&
		               (pwm_run_reg || (state_next == css_pkg::CSS_RUN) ||
		                (state_reg == css_pkg::CSS_SOFT && tm_done));    // see R4
	end

	// Fault path is two sync flops plus this one, far inside 10 us
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bias_reg    <= 1'b0;
			power_reg   <= 1'b0;
			flag_reg    <= 1'b0;
			latch_reg   <= 1'b0;
			pwm_run_reg <= 1'b0;
		end else begin
			bias_reg    <= bias_next;
			power_reg   <= power_next;
			flag_reg    <= flag_next;                                    // see R11
			latch_reg   <= latch_next;
			pwm_run_reg <= pwm_run_next;
		end
	end

	// ****************************************************************
	// Temperature PWM
	// ****************************************************************

	// Local bundle to the generator; the top keeps plain ports
	css_pwm_if pwm_if ();

	// Run request and held reading go out on the bundle
	assign pwm_if.run    = pwm_run_reg;
	assign pwm_if.temp_c = temp_reg;

	css_temp_pwm u_pwm (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.pwm    (pwm_if.gen)
	);

	// ****************************************************************
	// Output pins
	// ****************************************************************

	// All of these leave straight from flops
	assign bias_en_o              = bias_reg;
	assign power_stage_o          = power_reg;
	assign ready_fault_flag_o     = flag_reg;
	assign fault_latched_o        = latch_reg;

	// The PWM pin pair leaves from the generator's flops
	assign temperature_pwm_out_o  = pwm_if.level;
	assign temperature_pwm_oe_n_o = pwm_if.drive_n;

endmodule

// ### bench/css_seq_sva.sv
`timescale 1ns/1ps
// ********
// Pin checker for the status sequencer
// ********
module css_seq_sva #(
	parameter int unsigned T_UV_DELAY_CYC = 4,
	parameter int unsigned T_EN_START_CYC = 20,
	parameter int unsigned T_TM_CYC       = 10,
	parameter int unsigned T_FLAG_CYC     = 40
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Inputs
	input wire logic enable_i,
	input wire logic pri_above_recovery_i,
	input wire logic pri_below_lockout_i,
	input wire logic fault_i,
	// Outputs
	input wire logic bias_en_o,
	input wire logic power_stage_o,
	input wire logic temperature_pwm_out_o,
	input wire logic temperature_pwm_oe_n_o,
	input wire logic ready_fault_flag_o,
	input wire logic fault_latched_o
);
	localparam int QLO = T_UV_DELAY_CYC + T_EN_START_CYC;
	localparam int PER = 400;
	int   qcnt;
	int   pcnt;
	int   lo_age;
	int   rcnt;
	logic pwm_q;
	logic rise;
	logic run_seen;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	assign rise = temperature_pwm_out_o && !pwm_q;
	// Ages of qualification, power, lockout and PWM period
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			qcnt     <= 0;
			pcnt     <= 0;
			lo_age   <= 0;
			rcnt     <= 0;
			pwm_q    <= 1'b0;
			run_seen <= 1'b0;
		end else begin
			qcnt     <= (enable_i && pri_above_recovery_i && !fault_latched_o) ? qcnt + 1 : 0;
			pcnt     <= power_stage_o ? pcnt + 1 : 0;
			lo_age   <= pri_below_lockout_i ? 0 : lo_age + 1;
			pwm_q    <= temperature_pwm_out_o;
			rcnt     <= rise ? 1 : rcnt + 1;
			run_seen <= !temperature_pwm_oe_n_o && (run_seen || rise);
		end
	end

	// Start-up timing; sync stages give a few cycles of slack
	power_qual_a: assert property ($rose(power_stage_o) |-> qcnt >= QLO && qcnt <= QLO + 8)
		else $error("power stage rose at wrong qualified age");
	flag_delay_a: assert property ($rose(ready_fault_flag_o) |-> pcnt == T_FLAG_CYC)
		else $error("ready flag rose at wrong time");
	// The generator's own flop puts the pin one cycle behind the run request
	pwm_start_a: assert property ($fell(temperature_pwm_oe_n_o) |-> pcnt == T_TM_CYC + 1)
		else $error("temperature pwm started at wrong time");
	flag_power_a: assert property (ready_fault_flag_o |-> power_stage_o)
		else $error("ready flag without power stage");
	pwm_idle_a: assert property (!power_stage_o && !$past(power_stage_o) |->
		temperature_pwm_oe_n_o && !temperature_pwm_out_o)
		else $error("temperature pwm driven while power off");
	pwm_period_a: assert property (rise && run_seen |-> rcnt == PER)
		else $error("temperature pwm period wrong");
	// Shutdown paths
	fault_drop_a: assert property (fault_i [*3] |=> !ready_fault_flag_o && !power_stage_o)
		else $error("flag not dropped on fault");
	enable_off_a: assert property (!enable_i [*3] |=> !bias_en_o && !power_stage_o)
		else $error("bias or power on with enable low");
	latch_hold_a: assert property (fault_latched_o |-> !power_stage_o && !ready_fault_flag_o)
		else $error("power or flag up while latched");
	latch_exit_a: assert property ($fell(fault_latched_o) |-> lo_age <= 3)
		else $error("latch left without lockout");

	cover property ($rose(ready_fault_flag_o));
	cover property ($rose(fault_latched_o));
	cover property ($fell(bias_en_o));
endmodule

bind css_converter_status_sequencer css_seq_sva #(
	.T_UV_DELAY_CYC(T_UV_DELAY_CYC), .T_EN_START_CYC(T_EN_START_CYC),
	.T_TM_CYC(T_TM_CYC), .T_FLAG_CYC(T_FLAG_CYC)
) u_sva (
	.clk_i(clk_i), .rstn_i(rstn_i), .enable_i(enable_i),
	.pri_above_recovery_i(pri_above_recovery_i),
	.pri_below_lockout_i(pri_below_lockout_i), .fault_i(fault_i),
	.bias_en_o(bias_en_o), .power_stage_o(power_stage_o),
	.temperature_pwm_out_o(temperature_pwm_out_o),
	.temperature_pwm_oe_n_o(temperature_pwm_oe_n_o),
	.ready_fault_flag_o(ready_fault_flag_o), .fault_latched_o(fault_latched_o)
);

// ### bench/css_host_model.sv
`timescale 1ns/1ps
// ********
// Host supervisor: owns the enable pin, reads the pwm pin
// ********
module css_host_model (
	// Clock
	input  wire logic  clk_i,
	// Host intent
	input  wire logic  en_drive_i,
	input  wire logic  en_float_i,
	// Device pins
	input  wire logic  pwm_i,
	input  wire logic  pwm_oe_n_i,
	output logic       en_pin_o,
	output logic [9:0] duty_o,
	output logic [9:0] period_o
);
	logic       pin;
	logic       pin_q = 1'b1;
	logic [9:0] cnt   = 10'h000;
	logic [9:0] hi    = 10'h000;

	// Pull-up wins when nobody drives; in an array all hosts share it
	assign en_pin_o = en_float_i ? 1'b1 : en_drive_i;
	// Released pwm pin floats to the high level
	assign pin = pwm_oe_n_i ? 1'b1 : pwm_i;
	// High time and period, taken between rising edges
	always @(posedge clk_i) begin
		pin_q <= pin;
		if (pin && !pin_q) begin
			period_o <= cnt;
			duty_o   <= hi;
			cnt      <= 10'h001;
			hi       <= 10'h001;
		end else begin
			cnt <= cnt + 10'h001;
			hi  <= hi + {9'h000, pin};
		end
	end
endmodule

// ### bench/css_converter_status_sequencer_tb_top.sv
`timescale 1ns/1ps
// ********
// Status sequencer bench
// ********
module css_converter_status_sequencer_tb_top;
	localparam int UV  = 4;
	localparam int EN  = 20;
	localparam int TM  = 10;
	localparam int FL  = 40;
	localparam int PER = 400;
	logic               clk_i    = 1'b0;
	logic               rstn_i   = 1'b0;
	logic               en_drive = 1'b0;
	logic               en_float = 1'b0;
	logic               above    = 1'b0;
	logic               below    = 1'b0;
	logic               fault    = 1'b0;
	logic               tvalid   = 1'b0;
	css_pkg::css_temp_t tc       = 8'h1B;
	logic               en_pin, bias, power, pwm, oe_n, flag, latched;
	logic [9:0]         duty, period;
	int                 n_fail   = 0;
	int                 n_tests  = 0;
	int                 temps[6] = '{-50, -40, 0, 27, 85, 127};

	css_converter_status_sequencer #(.T_UV_DELAY_CYC(UV), .T_EN_START_CYC(EN),
		.T_TM_CYC(TM), .T_FLAG_CYC(FL)) dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .enable_i(en_pin),
		.pri_above_recovery_i(above), .pri_below_lockout_i(below), .fault_i(fault),
		.temp_c_i(tc), .temp_valid_i(tvalid), .bias_en_o(bias), .power_stage_o(power),
		.temperature_pwm_out_o(pwm), .temperature_pwm_oe_n_o(oe_n),
		.ready_fault_flag_o(flag), .fault_latched_o(latched));
	css_host_model host (.clk_i(clk_i), .en_drive_i(en_drive), .en_float_i(en_float),
		.pwm_i(pwm), .pwm_oe_n_i(oe_n), .en_pin_o(en_pin), .duty_o(duty), .period_o(period));

	always #5 clk_i = ~clk_i;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Sample just after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Duty from 1.27 V at 27 C, 10 mV per degree, 3.3 V high
	function automatic int exp_duty(input int t);
		int c;
		int d;
		c = t < -40 ? -40 : (t > 125 ? 125 : t);
		d = ((1270 + 10 * (c - 27)) * PER + 1650) / 3300;
		return d < 73 ? 73 : (d > 272 ? 272 : d);
	endfunction

	// Qualify and time each start-up step
	task automatic t_start(input logic flt, input logic stop);
		int n;
		int ntm;
		@(posedge clk_i);
		en_float <= flt;
		en_drive <= 1'b1;
		above    <= 1'b1;
		n = 0;
		while (power !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("power delay", n >= UV + EN && n <= UV + EN + 8, 1);
		chk("bias", bias, 1);
		if (!stop) begin
			n = 0;
			ntm = 0;
			while (flag !== 1'b1 && n < 2 * FL) begin
				tick(1);
				n++;
				if (oe_n === 1'b0 && ntm == 0)
					ntm = n;
			end
			// One cycle more for the generator's output flop
			chk("pwm start", ntm, TM + 1);
			chk("flag delay", n, FL);
		end
	endtask

	// New reading lands at the next period start
	task automatic t_temp(input int t);
		@(posedge clk_i);
		tc     <= t[7:0];
		tvalid <= 1'b1;
		@(posedge clk_i);
		tvalid <= 1'b0;
		tick(3 * PER);
		chk("period", period, PER);
		chk("duty", duty, exp_duty(t));
	endtask

	task automatic t_disable();
		@(posedge clk_i);
		en_float <= 1'b0;
		en_drive <= 1'b0;
		tick(4);
		chk("disabled", {bias, power, flag, oe_n}, 4'h1);
	endtask

	// Fault, a blocked restart, then lockout clears it
	task automatic t_fault(input int w);
		int n;
		tick(w);
		@(posedge clk_i);
		fault <= 1'b1;
		n = 0;
		while (latched !== 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		chk("fault response", n <= 3, 1);
		chk("fault pins", {flag, power}, 2'h0);
		// The PWM pin is released one cycle later, by the generator's flop
		tick(1);
		chk("pwm released", oe_n, 1);
		@(posedge clk_i);
		fault    <= 1'b0;
		en_drive <= 1'b0;
		tick(5);
		@(posedge clk_i);
		en_drive <= 1'b1;
		tick(UV + EN + 10);
		chk("still latched", {latched, power, flag}, 3'h4);
		@(posedge clk_i);
		above <= 1'b0;
		below <= 1'b1;
		tick(5);
		chk("latch cleared", latched, 0);
		@(posedge clk_i);
		below <= 1'b0;
	endtask

	task automatic tally_and_finish();
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		tick(2);
		chk("reset", {bias, power, pwm, oe_n, flag, latched}, 6'h04);
		t_start(1'b1, 1'b0);
		tick(2 * PER);
		chk("boot duty", duty, exp_duty(27));
		foreach (temps[i])
			t_temp(temps[i]);
		t_disable();
		t_start(1'b0, 1'b1);
		t_fault(2);
		t_start(1'b0, 1'b0);
		t_fault(PER);
		tally_and_finish();
	end

	// Run is near 9k cycles; give it about five times that
	initial begin
		#(10 * 50000);
		n_fail++;
		tally_and_finish();
	end
endmodule
